// File: design/fifo_cfg.sv
// fifo with reset-time mode and almost-flag offset setup
`timescale 1ns/1ns
`default_nettype none
`include "fifo_cfg_defs.svh"

module fifo_cfg (
  // clock, reset, enable
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   ce,
  // configuration pins
  input  wire logic                   master_reset_n,
  input  wire logic                   endian_timing_select,
  input  wire logic                   offset_sel0_serial_in,
  input  wire logic                   offset_sel1_serial_load,
  input  wire logic                   offset_sel2,
  // port a
  input  wire fifo_cfg_pkg::port_ctl_t port_a_ctl,
  input  wire logic [35:0]            port_a_in,
  output logic [35:0]                 port_a_out,
  output logic                        port_a_oe_n,
  // port b
  input  wire fifo_cfg_pkg::port_ctl_t port_b_ctl,
  output logic [35:0]                 port_b_out,
  output logic                        port_b_oe_n,
  // flags
  output logic                        full_or_input_ready,
  output logic                        empty_or_output_ready,
  output logic                        almost_empty_flag_n,
  output logic                        almost_full_flag_n,
  output logic                        fall_through_mode,
  // avalon-mm slave
  input  wire logic [3:0]             address,
  input  wire logic                   read,
  input  wire logic                   write,
  input  wire logic [31:0]            writedata,
  input  wire logic [3:0]             byteenable,
  output logic [31:0]                 readdata,
  output logic                        waitrequest
);

  fifo_cfg_pkg::state_t s_q;
  fifo_cfg_pkg::state_t s_d;

  logic [35:0] mem [0:(1<<`FIFO_AW)-1];
  logic [35:0] b_data_q;
  logic [35:0] a_zero_q;

  logic        wr_req;
  logic        rd_req;
  logic        wr_mem;
  logic        wr_off;
  logic        load;
  logic        parallel;
  logic [10:0] off_val;
  logic [11:0] count_d;
  logic [11:0] af_lim;
  logic [31:0] rd_mux;

  always_comb begin
    s_d = s_q;
    // pins not tied to mclk pass two flops first
    s_d.mr_s1  = master_reset_n;
    s_d.mr_s2  = s_q.mr_s1;
    s_d.fs_s1  = {offset_sel2, offset_sel1_serial_load,
                  offset_sel0_serial_in};
    s_d.fs_s2  = s_q.fs_s1;
    s_d.ets_s1 = endian_timing_select;
    s_d.ets_s2 = s_q.ets_s1;

    parallel = (s_q.method == fifo_cfg_pkg::M_PAR_PLAIN) ||
               (s_q.method == fifo_cfg_pkg::M_PAR_IP);
    wr_req = !port_a_ctl.select_n && port_a_ctl.direction &&
             port_a_ctl.strobe && !port_a_ctl.mail_sel &&
             s_q.in_ready && s_q.ctrl_en;
    rd_req = !port_b_ctl.select_n && port_b_ctl.direction &&
             port_b_ctl.strobe && !port_b_ctl.mail_sel &&
             s_q.out_ready && s_q.ctrl_en;
    wr_off = wr_req && parallel && (s_q.par_cnt < `PAR_LOADS);
    wr_mem = wr_req && !wr_off;
    if (s_q.method == fifo_cfg_pkg::M_PAR_IP) begin
      off_val = {port_a_in[11:9], port_a_in[7:0]};
    end else begin
      off_val = port_a_in[10:0];
    end

    // outputs register loads: explicit read, or fall-through fill
    if (s_q.fall_through_mode) begin
      load = (rd_req || !s_q.outv) &&
             (s_q.count != 12'h000);
    end else begin
      load = rd_req;
    end
    if (s_q.phase != fifo_cfg_pkg::PH_RUN) begin
      load = 1'b0;
    end
    count_d = s_q.count + {11'h000, wr_mem} - {11'h000, load};
    af_lim  = `FIFO_DEPTH - {1'b0, s_q.ofs_y};

    if (!s_q.mr_s2) begin
      s_d.phase   = fifo_cfg_pkg::PH_HOLD;
      s_d.wptr    = '0;
      s_d.rptr    = '0;
      s_d.count   = '0;
      s_d.outv    = 1'b0;
      s_d.in_ready    = 1'b0;
      s_d.out_ready   = 1'b0;
      s_d.alm_empty_n = 1'b0;
      s_d.alm_full_n  = 1'b1;
      s_d.prog_ok = 1'b0;
    end else begin
      unique case (s_q.phase)
        fifo_cfg_pkg::PH_HOLD: begin
          // first cycle after release: latch the programming method
          s_d.phase   = fifo_cfg_pkg::PH_PICK;
          s_d.par_cnt = '0;
          s_d.ser_cnt = '0;
          s_d.prog_ok = 1'b1;
          s_d.method  = fifo_cfg_pkg::M_PRESET;
          unique case (s_q.fs_s2)
            `FS_HHH: begin
              s_d.ofs_x = `PRESET_64;
              s_d.ofs_y = `PRESET_64;
            end
            `FS_HHL: begin
              s_d.ofs_x = `PRESET_16;
              s_d.ofs_y = `PRESET_16;
            end
            `FS_HLH: begin
              s_d.ofs_x = `PRESET_8;
              s_d.ofs_y = `PRESET_8;
            end
            `FS_LHH: begin
              s_d.ofs_x = `PRESET_256;
              s_d.ofs_y = `PRESET_256;
            end
            `FS_LLH: begin
              s_d.ofs_x = `PRESET_1024;
              s_d.ofs_y = `PRESET_1024;
            end
            `FS_LHL: begin
              s_d.method  = fifo_cfg_pkg::M_SERIAL;
              s_d.prog_ok = 1'b0;
            end
            `FS_HLL: s_d.method = fifo_cfg_pkg::M_PAR_PLAIN;
            `FS_LLL: s_d.method = fifo_cfg_pkg::M_PAR_IP;
          endcase
        end
        fifo_cfg_pkg::PH_PICK: begin
          s_d.fall_through_mode = !s_q.ets_s2;
          s_d.phase = fifo_cfg_pkg::PH_RUN;
          s_d.in_ready = s_q.prog_ok;
        end
        fifo_cfg_pkg::PH_RUN: begin
          // serial bits go msb first, Y then X
          if (s_q.method == fifo_cfg_pkg::M_SERIAL && !s_q.prog_ok) begin
            if (!s_q.fs_s2[1] && s_q.ser_cnt != `SER_BITS) begin
              s_d.ser_sr  = {s_q.ser_sr[20:0], s_q.fs_s2[0]};
              s_d.ser_cnt = s_q.ser_cnt + 5'h01;
            end
            if (s_q.ser_cnt == `SER_BITS) begin
              s_d.ofs_y   = s_q.ser_sr[21:11];
              s_d.ofs_x   = s_q.ser_sr[10:0];
              s_d.prog_ok = 1'b1;
            end
          end
          if (wr_off) begin
            if (s_q.par_cnt == 2'h0) begin
              s_d.ofs_y = off_val;
            end else begin
              s_d.ofs_x = off_val;
            end
            s_d.par_cnt = s_q.par_cnt + 2'h1;
          end
          if (wr_mem) begin
            s_d.wptr = s_q.wptr + 11'h001;
          end
          if (load) begin
            s_d.rptr = s_q.rptr + 11'h001;
          end
          if (s_q.fall_through_mode) begin
            if (load) begin
              s_d.outv = 1'b1;
            end else if (rd_req) begin
              s_d.outv = 1'b0;
            end
            s_d.out_ready = s_d.outv;
          end else begin
            s_d.out_ready = (count_d != 12'h000);
          end
          s_d.count       = count_d;
          s_d.in_ready    = s_d.prog_ok && (count_d != `FIFO_DEPTH);
          s_d.alm_empty_n = count_d > {1'b0, s_q.ofs_x};
          s_d.alm_full_n  = count_d < af_lim;
        end
        default: s_d.phase = fifo_cfg_pkg::PH_HOLD;
      endcase
    end

    s_d.a_oe_n = port_a_ctl.select_n || port_a_ctl.direction;
    s_d.b_oe_n = port_b_ctl.select_n || !port_b_ctl.direction;

    // register bus: one wait cycle, then answer
    unique case (address)
      `REG_CTRL:    rd_mux = {31'h0, s_q.ctrl_en};
      `REG_STATUS:  rd_mux = {12'h000, s_q.count, s_q.alm_full_n,
                              s_q.alm_empty_n, s_q.out_ready,
                              s_q.in_ready, s_q.prog_ok,
                              s_q.method, s_q.fall_through_mode};
      `REG_OFFSETS: rd_mux = {5'h00, s_q.ofs_y, 5'h00, s_q.ofs_x};
      default:      rd_mux = 32'h0;
    endcase
    s_d.waitreq = 1'b1;
    if ((read || write) && s_q.waitreq) begin
      s_d.waitreq = 1'b0;
      s_d.rdata   = read ? rd_mux : 32'h0;
    end
    if (write && !s_q.waitreq && address == `REG_CTRL && byteenable[0]) begin
      s_d.ctrl_en = writedata[0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{phase: fifo_cfg_pkg::PH_HOLD,
               method: fifo_cfg_pkg::M_PRESET,
               alm_full_n: 1'b1, a_oe_n: 1'b1, b_oe_n: 1'b1,
               ctrl_en: `CTRL_RESET, waitreq: 1'b1, default: '0};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // storage has no reset; pointers guard it
  always_ff @(posedge mclk) begin
    if (ce && wr_mem && s_q.phase == fifo_cfg_pkg::PH_RUN) begin
      mem[s_q.wptr] <= port_a_in;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      b_data_q <= 36'h0;
      a_zero_q <= 36'h0;
    end else if (ce) begin
      a_zero_q <= 36'h0;
      if (load) begin
        b_data_q <= mem[s_q.rptr];
      end
    end
  end

  assign port_a_out            = a_zero_q;
  assign port_a_oe_n           = s_q.a_oe_n;
  assign port_b_out            = b_data_q;
  assign port_b_oe_n           = s_q.b_oe_n;
  assign full_or_input_ready   = s_q.in_ready;
  assign empty_or_output_ready = s_q.out_ready;
  assign almost_empty_flag_n   = s_q.alm_empty_n;
  assign almost_full_flag_n    = s_q.alm_full_n;
  assign fall_through_mode     = s_q.fall_through_mode;
  assign readdata              = s_q.rdata;
  assign waitrequest           = s_q.waitreq;

endmodule

`default_nettype wire

// File: design/fifo_cfg_defs.svh
// constants for the fifo configuration and port-control block
`ifndef FIFO_CFG_DEFS_SVH
`define FIFO_CFG_DEFS_SVH

`define FIFO_DEPTH        12'h800
`define FIFO_AW           11
`define FIFO_CW           12
`define FIFO_DW           36
`define OFF_W             11
`define SER_BITS          5'h16

`define PRESET_64         11'h040
`define PRESET_16         11'h010
`define PRESET_8          11'h008
`define PRESET_256        11'h100
`define PRESET_1024       11'h400

`define FS_HHH            3'h7
`define FS_HHL            3'h6
`define FS_HLH            3'h5
`define FS_LHH            3'h3
`define FS_LLH            3'h1
`define FS_LHL            3'h2
`define FS_HLL            3'h4
`define FS_LLL            3'h0

`define PAR_LOADS         2'h2

`define REG_CTRL          4'h0
`define REG_STATUS        4'h4
`define REG_OFFSETS       4'h8
`define CTRL_RESET        1'h1
`define ST_COUNT_LSB      8
`define OFS_Y_LSB         16

`endif

// File: design/fifo_cfg_pkg.sv
// types for the fifo configuration and port-control block
package fifo_cfg_pkg;

  typedef enum logic [1:0] {
    M_PRESET,
    M_SERIAL,
    M_PAR_PLAIN,
    M_PAR_IP
  } method_t;

  typedef enum logic [1:0] {
    PH_HOLD,
    PH_PICK,
    PH_RUN
  } phase_t;

  // one port's control pins
  typedef struct packed {
    logic select_n;
    logic direction;
    logic strobe;
    logic mail_sel;
  } port_ctl_t;

  typedef struct packed {
    logic        mr_s1;
    logic        mr_s2;
    logic [2:0]  fs_s1;
    logic [2:0]  fs_s2;
    logic        ets_s1;
    logic        ets_s2;
    phase_t      phase;
    method_t     method;
    logic        fall_through_mode;
    logic [10:0] ofs_x;
    logic [10:0] ofs_y;
    logic [1:0]  par_cnt;
    logic [4:0]  ser_cnt;
    logic [21:0] ser_sr;
    logic        prog_ok;
    logic [10:0] wptr;
    logic [10:0] rptr;
    logic [11:0] count;
    logic        outv;
    logic        in_ready;
    logic        out_ready;
    logic        alm_empty_n;
    logic        alm_full_n;
    logic        a_oe_n;
    logic        b_oe_n;
    logic        ctrl_en;
    logic        waitreq;
    logic [31:0] rdata;
  } state_t;

endpackage

// File: verification/fifo_cfg_assertions.sv
// assertion checker for the fifo configuration block
`timescale 1ns/1ns
`default_nettype none
module fifo_cfg_assertions (
  // clock and reset
  input wire logic                    mclk,
  input wire logic                    rst_n,
  // config pins
  input wire logic                    master_reset_n,
  input wire logic                    offset_sel0_serial_in,
  input wire logic                    offset_sel1_serial_load,
  input wire logic                    offset_sel2,
  // ports
  input wire fifo_cfg_pkg::port_ctl_t port_a_ctl,
  input wire fifo_cfg_pkg::port_ctl_t port_b_ctl,
  input wire logic                    port_a_oe_n,
  input wire logic                    port_b_oe_n,
  input wire logic [35:0]             port_b_out,
  // flags and bus
  input wire logic                    full_or_input_ready,
  input wire logic                    empty_or_output_ready,
  input wire logic                    fall_through_mode,
  input wire logic                    read,
  input wire logic                    write,
  input wire logic                    waitrequest
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic       wr_ok, rd_ok, ser_pat, ser_q;
  logic [4:0] bits_q;
  assign wr_ok = port_a_ctl == 4'h6 && full_or_input_ready;
  assign rd_ok = port_b_ctl == 4'h6 && empty_or_output_ready;
  assign ser_pat = {offset_sel2, offset_sel1_serial_load,
                    offset_sel0_serial_in} == 3'h2;
  // pin-level bit count, so it runs ahead of the synced design
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ser_q  <= 1'b0;
      bits_q <= 5'h0;
    end else if (!master_reset_n) begin
      ser_q  <= ser_pat;
      bits_q <= 5'h0;
    end else if (ser_q && !offset_sel1_serial_load && bits_q != 5'h1f) begin
      bits_q <= bits_q + 5'h1;
    end
  end
  AST_A_OE: assert property (port_a_oe_n ==
    ($past(port_a_ctl.select_n) | $past(port_a_ctl.direction)))
    else $error("port a drive enable wrong");
  AST_B_OE: assert property (port_b_oe_n ==
    ($past(port_b_ctl.select_n) | !$past(port_b_ctl.direction)))
    else $error("port b drive enable wrong");
  AST_MR_CLEAR: assert property (!master_reset_n [*3] |->
    ##2 (!full_or_input_ready && !empty_or_output_ready))
    else $error("flags not cleared by master reset");
  AST_IR_RISE: assert property ($rose(master_reset_n) && !ser_pat
    |-> ##[1:6] full_or_input_ready) else $error("input ready late");
  AST_STD_FIRST: assert property (!fall_through_mode &&
    $rose(empty_or_output_ready) |-> $past(wr_ok))
    else $error("empty flag rose without write");
  AST_FT_FIRST: assert property (fall_through_mode &&
    $rose(empty_or_output_ready) |-> $past(wr_ok, 2))
    else $error("output ready rose without write");
  AST_STD_READ: assert property (!fall_through_mode &&
    master_reset_n && $past(master_reset_n, 3) && $changed(port_b_out)
    |-> $past(rd_ok)) else $error("output word changed without read");
  AST_SER_HOLD: assert property (master_reset_n && ser_q &&
    bits_q < 5'h16 |-> !full_or_input_ready)
    else $error("input ready during serial load");
  AST_SER_DONE: assert property (master_reset_n && ser_q &&
    bits_q == 5'h16 |-> ##[0:6] full_or_input_ready)
    else $error("input ready missing after serial load");
  AST_BUS_ANS: assert property ((read || write) && waitrequest
    |=> !waitrequest) else $error("bus answer late");
  cover property (fall_through_mode && $rose(empty_or_output_ready));
  cover property (ser_q && bits_q == 5'h16);
  cover property (wr_ok && rd_ok);
endmodule
bind fifo_cfg fifo_cfg_assertions u_chk (.mclk, .rst_n, .master_reset_n,
  .offset_sel0_serial_in, .offset_sel1_serial_load, .offset_sel2,
  .port_a_ctl, .port_b_ctl, .port_a_oe_n, .port_b_oe_n, .port_b_out,
  .full_or_input_ready, .empty_or_output_ready, .fall_through_mode,
  .read, .write, .waitrequest);
`default_nettype wire

// File: verification/fifo_far_side.sv
// far-side controllers: port a writer, port b reader, config pins
`timescale 1ns/1ns
`default_nettype none
module fifo_far_side (
  // clock
  input  wire logic                   mclk,
  // config pins
  output logic                        master_reset_n,
  output logic                        endian_timing_select,
  output logic                        offset_sel0_serial_in,
  output logic                        offset_sel1_serial_load,
  output logic                        offset_sel2,
  // port controls and data
  output var fifo_cfg_pkg::port_ctl_t port_a_ctl,
  output logic [35:0]                 port_a_in,
  output var fifo_cfg_pkg::port_ctl_t port_b_ctl
);
  initial begin
    master_reset_n = 1'b1;
    endian_timing_select = 1'b1;
    {offset_sel2, offset_sel1_serial_load, offset_sel0_serial_in} = 3'h7;
    port_a_ctl = 4'h8;
    port_b_ctl = 4'h8;
    port_a_in = 36'h0;
  end
  // pins change here and in ser, held well past release
  task automatic mreset(logic [2:0] fs, logic ets);
    @(posedge mclk);
    {offset_sel2, offset_sel1_serial_load, offset_sel0_serial_in} <= fs;
    endian_timing_select <= ets;
    master_reset_n <= 1'b0;
    repeat (5) @(posedge mclk);
    master_reset_n <= 1'b1;
    repeat (6) @(posedge mclk);
  endtask
  // released data lines toggle so stale values never match
  task automatic cyc(logic [3:0] ac, logic [35:0] ad, logic [3:0] bc);
    port_a_ctl <= ac;
    port_a_in <= ac[2] ? ad : ~port_a_in;
    port_b_ctl <= bc;
    @(posedge mclk);
  endtask
  task automatic ser(logic [21:0] bits);
    for (int i = 21; i >= 0; i--) begin
      offset_sel0_serial_in <= bits[i];
      offset_sel1_serial_load <= 1'b0;
      @(posedge mclk);
    end
    offset_sel1_serial_load <= 1'b1;
  endtask
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench for the fifo configuration block
`timescale 1ns/1ns
`default_nettype none
`include "fifo_cfg_defs.svh"
module tb_top;
  logic        mclk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0;
  logic        master_reset_n, endian_timing_select, offset_sel2;
  logic        offset_sel0_serial_in, offset_sel1_serial_load;
  logic        port_a_oe_n, port_b_oe_n, full_or_input_ready;
  logic        empty_or_output_ready, almost_empty_flag_n;
  logic        almost_full_flag_n, fall_through_mode, waitrequest;
  logic [35:0] port_a_in, port_a_out, port_b_out;
  logic [3:0]  address = 4'h0;
  logic [31:0] writedata = 32'h0, readdata, rd;
  int          num_errors = 0, tests_run = 0;
  logic [2:0]  fs_tab [5] = '{`FS_HHH, `FS_HHL, `FS_HLH, `FS_LHH, `FS_LLH};
  logic [10:0] pv_tab [5] = '{`PRESET_64, `PRESET_16, `PRESET_8,
                              `PRESET_256, `PRESET_1024};
  fifo_cfg_pkg::port_ctl_t port_a_ctl, port_b_ctl;
  always #2 mclk = ~mclk;
  fifo_cfg DUT (.mclk, .rst_n, .ce(1'b1), .master_reset_n,
    .endian_timing_select, .offset_sel0_serial_in, .offset_sel1_serial_load,
    .offset_sel2, .port_a_ctl, .port_a_in, .port_a_out, .port_a_oe_n,
    .port_b_ctl, .port_b_out, .port_b_oe_n, .full_or_input_ready,
    .empty_or_output_ready, .almost_empty_flag_n, .almost_full_flag_n,
    .fall_through_mode, .address, .read, .write, .writedata,
    .byteenable(4'hf), .readdata, .waitrequest);
  fifo_far_side far (.mclk, .master_reset_n, .endian_timing_select,
    .offset_sel0_serial_in, .offset_sel1_serial_load, .offset_sel2,
    .port_a_ctl, .port_a_in, .port_b_ctl);
  // waits for the answer however long; only the watchdog ends a hang
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
    address <= a;
    writedata <= d;
    read <= !w;
    write <= w;
    do begin
      @(posedge mclk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic chk(string nm, logic [35:0] e, logic [35:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge mclk);
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b0, 4'h0, 32'h0);
    chk("ctrl off", 36'h0, rd);
    far.cyc(4'h6, 36'h1, 4'h8);
    far.cyc(4'h8, 36'h0, 4'h8);
    bus(1'b0, 4'h4, 32'h0);
    chk("blocked", 36'h0, rd[19:8]);
    bus(1'b1, 4'h0, 32'h1);
    bus(1'b0, 4'h0, 32'h0);
    chk("ctrl", 36'h1, rd);
    bus(1'b1, 4'hc, 32'hffff_ffff);
    bus(1'b0, 4'hc, 32'h0);
    chk("unmapped", 36'h0, rd);
    for (int i = 0; i < 5; i++) begin
      far.mreset(fs_tab[i], i[0]);
      chk("mode", !i[0], fall_through_mode);
      bus(1'b0, 4'h8, 32'h0);
      chk("preset", {5'h0, pv_tab[i], 5'h0, pv_tab[i]}, rd);
    end
    far.cyc(4'h6, 36'h9_8765_4321, 4'h8);
    far.cyc(4'h6, 36'h1_2345_6789, 4'h8);
    far.cyc(4'h8, 36'h0, 4'h8);
    far.cyc(4'h8, 36'h0, 4'h8);
    chk("fall", 36'h9_8765_4321, port_b_out);
    far.cyc(4'h8, 36'h0, 4'h6);
    far.cyc(4'h8, 36'h0, 4'h8);
    chk("ft read", 36'h1_2345_6789, port_b_out);
    far.mreset(`FS_HLL, 1'b1);
    far.cyc(4'h6, 36'hf_ffff_f9a5, 4'h8);
    far.cyc(4'h6, 36'h0_0000_0123, 4'h8);
    far.cyc(4'h7, 36'h5_5555_5555, 4'h8);
    far.cyc(4'h6, 36'ha_bcde_f012, 4'h8);
    far.cyc(4'h8, 36'h0, 4'h8);
    chk("no fall", 36'h0, port_b_out === 36'ha_bcde_f012);
    bus(1'b0, 4'h8, 32'h0);
    chk("par ofs", {5'h0, 11'h1a5, 5'h0, 11'h123}, rd);
    bus(1'b0, 4'h4, 32'h0);
    chk("par stat", 36'h1bc, rd);
    far.cyc(4'h6, 36'h3_3333_3333, 4'h6);
    far.cyc(4'h8, 36'h0, 4'h8);
    chk("std read", 36'ha_bcde_f012, port_b_out);
    bus(1'b0, 4'h4, 32'h0);
    chk("std count", 36'h1, rd[19:8]);
    far.mreset(`FS_LLL, 1'b0);
    far.cyc(4'h6, 36'h0_0000_0b5a, 4'h8);
    far.cyc(4'h6, 36'h0_0000_0301, 4'h8);
    far.cyc(4'h8, 36'h0, 4'h8);
    bus(1'b0, 4'h8, 32'h0);
    chk("ip ofs", {5'h0, 11'h55a, 5'h0, 11'h101}, rd);
    bus(1'b0, 4'h4, 32'h0);
    chk("interleaved_parity_mode", 36'h7, rd[2:0]);
    far.mreset(`FS_LHL, 1'b1);
    far.cyc(4'h6, 36'h7_7777_7777, 4'h8);
    far.cyc(4'h8, 36'h0, 4'h8);
    far.ser({11'h2c3, 11'h0a7});
    repeat (8) @(posedge mclk);
    chk("ser ready", 36'h1, full_or_input_ready);
    bus(1'b0, 4'h8, 32'h0);
    chk("ser ofs", {5'h0, 11'h2c3, 5'h0, 11'h0a7}, rd);
    bus(1'b0, 4'h4, 32'h0);
    chk("ser stat", 36'h9a, rd);
    chk("ef pin", 36'h0, empty_or_output_ready);
    chk("ae pin", 36'h0, almost_empty_flag_n);
    chk("af pin", 36'h1, almost_full_flag_n);
    far.cyc(4'h0, 36'h0, 4'h4);
    far.cyc(4'h8, 36'h0, 4'h8);
    chk("a oe", 36'h0, port_a_oe_n);
    chk("b oe", 36'h0, port_b_oe_n);
    chk("a out", 36'h0, port_a_out);
    end_sim();
  end
endmodule
`default_nettype wire
